//--- adcr_regs.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module adcr_regs
  import adcr_pkg::*;
#(
  parameter int SAMPLE_W = 20
) (
  input  wire logic                ref_clk_in,        // System clock, 100 MHz
  input  wire logic                rst_in,            // Sync reset, active high
  input  wire logic                ce_in,             // Clock enable, freezes state
  input  wire logic                spi_cs_n_in,       // Control port select, active low
  input  wire logic                spi_sclk_in,       // Control port clock
  input  wire logic                spi_mosi_in,       // Control port data in
  output logic                     spi_miso_out,      // Control port data out
  output logic                     spi_miso_oe_out,   // Data out enable
  input  wire logic                headset_short_in,  // Headset short detector
  input  wire logic                usb_supply_in,     // USB supply present
  input  wire logic                sample_valid_in,   // Sample pair strobe
  input  wire logic [SAMPLE_W-1:0] left_sample_in,    // Left input sample
  input  wire logic [SAMPLE_W-1:0] right_sample_in,   // Right input sample
  output logic                     mix_valid_out,     // Mixed pair strobe
  output logic [SAMPLE_W-1:0]      left_mix_out,      // Left mixer output
  output logic [SAMPLE_W-1:0]      right_mix_out,     // Right mixer output
  output adcr_cfg_s                cfg_out,           // Decoded controls
  output logic                     irq_out            // Interrupt request
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [4:0] pins_raw;
  logic [4:0] pins_sync;
  logic       cs_n_s;
  logic       sclk_s;
  logic       mosi_s;
  logic       hs_s;
  logic       usb_s;

  // Bundle pins; select goes in inverted so a cleared chain reads deselected
  assign pins_raw = {usb_supply_in, headset_short_in, spi_mosi_in, spi_sclk_in, ~spi_cs_n_in};
  assign cs_n_s   = ~pins_sync[0];
  assign sclk_s   = pins_sync[1];
  assign mosi_s   = pins_sync[2];
  assign hs_s     = pins_sync[3];
  assign usb_s    = pins_sync[4];

  adcr_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk_in  (ref_clk_in),
    .rst_in  (rst_in),
    .ce_in   (ce_in),
    .pin_in  (pins_raw),
    .sync_out(pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] mixer_control_q;
  logic [7:0] clock_ratio_control_q;
  logic [7:0] format_filter_control_q;
  logic [7:0] power_precharge_control_q;
  logic [7:0] converter_soft_reset_q;
  logic [7:0] interrupt_enable_mask_q;
  logic [7:0] flags_status;

  // Read mux for one register offset
  function automatic logic [7:0] rd_data(input logic [6:0] addr);
    logic [7:0] val;
    val = 8'h00;
    if (addr == ADCR_OFS_MIXER_CONTROL) begin
      val = mixer_control_q;
    end else if (addr == ADCR_OFS_CLOCK_RATIO) begin
      val = clock_ratio_control_q;
    end else if (addr == ADCR_OFS_FORMAT_FILTER) begin
      val = format_filter_control_q;
    end else if (addr == ADCR_OFS_POWER_PRECHG) begin
      val = power_precharge_control_q;
    end else if (addr == ADCR_OFS_SOFT_RESET) begin
      val = converter_soft_reset_q;
    end else if (addr == ADCR_OFS_FLAGS_STATUS) begin
      val = flags_status;
    end else if (addr == ADCR_OFS_IRQ_MASK) begin
      val = interrupt_enable_mask_q;
    end
    return val;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Serial control port

  adcr_state_e st_q;
  adcr_state_e st_d;
  logic        sclk_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  tx_q;
  logic [6:0]  addr_q;
  logic        rd_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [7:0]  rx_byte;
  logic        hdr_done;
  logic        wr_commit;

  // Edge detection on the filtered clock
  assign sclk_rise = sclk_s & ~sclk_q;
  assign sclk_fall = ~sclk_s & sclk_q;
  assign rx_byte   = {sh_q[6:0], mosi_s};
  assign hdr_done  = (st_q == ADCR_ST_HDR) && sclk_rise && (cnt_q == ADCR_HDR_LAST_BIT);
  assign wr_commit = (st_q == ADCR_ST_DATA) && sclk_rise && (cnt_q == ADCR_DATA_LAST_BIT) && !rd_q;

  // Data out drives only while selected
  assign spi_miso_out    = tx_q[7];
  assign spi_miso_oe_out = ~cs_n_s;

  // Frame sequencing
  always_comb begin
    st_d = st_q;
    case (st_q)
      ADCR_ST_IDLE: begin
        if (!cs_n_s) st_d = ADCR_ST_HDR;
      end
      ADCR_ST_HDR: begin
        if (cs_n_s) st_d = ADCR_ST_IDLE;
        else if (hdr_done) st_d = ADCR_ST_DATA;
      end
      ADCR_ST_DATA: begin
        if (cs_n_s) st_d = ADCR_ST_IDLE;
        else if (sclk_rise && (cnt_q == ADCR_DATA_LAST_BIT)) st_d = ADCR_ST_DONE;
      end
      ADCR_ST_DONE: begin
        if (cs_n_s) st_d = ADCR_ST_IDLE;
      end
      default: begin
        st_d = ADCR_ST_IDLE;
      end
    endcase
  end

  // Shift, count and header capture
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_q   <= ADCR_ST_IDLE;
      sclk_q <= 1'b0;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      addr_q <= 7'h00;
      rd_q   <= 1'b0;
    end else if (ce_in) begin
      st_q   <= st_d;
      sclk_q <= sclk_s;
      if (cs_n_s) begin
        cnt_q <= 4'h0;
      end else if (sclk_rise && (st_q != ADCR_ST_DONE)) begin
        cnt_q <= cnt_q + 4'h1;
        sh_q  <= rx_byte;
      end
      if (hdr_done) begin
        rd_q   <= rx_byte[7];
        addr_q <= rx_byte[6:0];
      end
    end
  end

  // Read data loads on first data fall, then shifts
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_q <= 8'h00;
    end else if (ce_in) begin
      if (cs_n_s) begin
        tx_q <= 8'h00;
      end else if ((st_q == ADCR_ST_DATA) && sclk_fall) begin
        tx_q <= (cnt_q == ADCR_DATA_FIRST) ? (rd_q ? rd_data(addr_q) : 8'h00) : {tx_q[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes

  logic wr_mix;
  logic wr_clk;
  logic wr_fmt;
  logic wr_pwr;
  logic wr_rst;
  logic wr_msk;

  // Address decode for the committing write
  assign wr_mix = wr_commit && (addr_q == ADCR_OFS_MIXER_CONTROL);
  assign wr_clk = wr_commit && (addr_q == ADCR_OFS_CLOCK_RATIO);
  assign wr_fmt = wr_commit && (addr_q == ADCR_OFS_FORMAT_FILTER);
  assign wr_pwr = wr_commit && (addr_q == ADCR_OFS_POWER_PRECHG);
  assign wr_rst = wr_commit && (addr_q == ADCR_OFS_SOFT_RESET);
  assign wr_msk = wr_commit && (addr_q == ADCR_OFS_IRQ_MASK);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mixer_control_q <= ADCR_RST_MIXER_CONTROL;
    end else if (ce_in && wr_mix) begin
      mixer_control_q <= rx_byte & ADCR_MSK_MIXER_CONTROL;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      clock_ratio_control_q <= ADCR_RST_CLOCK_RATIO;
    end else if (ce_in && wr_clk) begin
      clock_ratio_control_q <= rx_byte & ADCR_MSK_CLOCK_RATIO;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      format_filter_control_q <= ADCR_RST_FORMAT_FILTER;
    end else if (ce_in && wr_fmt) begin
      format_filter_control_q <= rx_byte & ADCR_MSK_FORMAT_FILTER;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      power_precharge_control_q <= ADCR_RST_POWER_PRECHG;
    end else if (ce_in && wr_pwr) begin
      power_precharge_control_q <= rx_byte & ADCR_MSK_POWER_PRECHG;
    end
  end

  // soft resets; locked bit never stored
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      converter_soft_reset_q <= ADCR_RST_SOFT_RESET;
    end else if (ce_in && wr_rst) begin
      converter_soft_reset_q <= rx_byte & ADCR_MSK_SOFT_RESET;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      interrupt_enable_mask_q <= ADCR_RST_IRQ_MASK;
    end else if (ce_in && wr_msk) begin
      interrupt_enable_mask_q <= rx_byte & ADCR_MSK_IRQ_MASK;
    end
  end

  assign flags_status = {6'h00, usb_s, hs_s} & ADCR_MSK_FLAGS_STATUS;

  ////////////////////////////////////////////////////////////////////////////////
  // Control decode

  assign cfg_out.left_mix_left_src_en   = mixer_control_q[ADCR_BIT_LMIX_L];
  assign cfg_out.left_mix_right_src_en  = mixer_control_q[ADCR_BIT_LMIX_R];
  assign cfg_out.right_mix_left_src_en  = mixer_control_q[ADCR_BIT_RMIX_L];
  assign cfg_out.right_mix_right_src_en = mixer_control_q[ADCR_BIT_RMIX_R];
  assign cfg_out.left_mix_invert        = mixer_control_q[ADCR_BIT_LMIX_INV];
  assign cfg_out.right_mix_invert       = mixer_control_q[ADCR_BIT_RMIX_INV];
  assign cfg_out.mclk_ratio_sel         = clock_ratio_control_q[ADCR_BIT_MCLK_RATIO];
  assign cfg_out.sample_len             = format_filter_control_q[ADCR_BIT_SLEN_LO +: 2];
  assign cfg_out.deemphasis_en          = format_filter_control_q[ADCR_BIT_DEEMPH];
  assign cfg_out.dither_en              = format_filter_control_q[ADCR_BIT_DITHER];
  assign cfg_out.frame_fmt              = format_filter_control_q[ADCR_BIT_FRAME_LO +: 2];
  assign cfg_out.master_power_on        = power_precharge_control_q[ADCR_BIT_PWR_ON];
  assign cfg_out.master_precharge       = power_precharge_control_q[ADCR_BIT_PRECHG];
  assign cfg_out.left_in_precharge      = power_precharge_control_q[2];
  assign cfg_out.right_in_precharge     = power_precharge_control_q[3];
  assign cfg_out.left_out_precharge     = power_precharge_control_q[4];
  assign cfg_out.right_out_precharge    = power_precharge_control_q[5];
  assign cfg_out.core_reset_n           = converter_soft_reset_q[ADCR_BIT_CORE_RSTN];
  assign cfg_out.filter_reset_n         = converter_soft_reset_q[ADCR_BIT_FILT_RSTN];

  ////////////////////////////////////////////////////////////////////////////////
  // Digital mixer

  // One channel: select, halve when both, then optional invert
  function automatic logic [SAMPLE_W-1:0] mix(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b,
                                              input logic en_a, input logic en_b, input logic inv);
    logic signed [SAMPLE_W:0] sum;
    logic [SAMPLE_W-1:0]      res;
    sum = $signed({a[SAMPLE_W-1], a} & {(SAMPLE_W+1){en_a}}) + $signed({b[SAMPLE_W-1], b} & {(SAMPLE_W+1){en_b}});
    res = (en_a && en_b) ? sum[SAMPLE_W:1] : sum[SAMPLE_W-1:0];
    return inv ? (~res + {{(SAMPLE_W-1){1'b0}}, 1'b1}) : res;
  endfunction

  logic [SAMPLE_W-1:0] left_mix_q;
  logic [SAMPLE_W-1:0] right_mix_q;
  logic                mix_valid_q;

  assign left_mix_out  = left_mix_q;
  assign right_mix_out = right_mix_q;
  assign mix_valid_out = mix_valid_q;

  // mix registers; core reset holds them at zero
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || (ce_in && !cfg_out.core_reset_n)) begin
      left_mix_q  <= '0;
      right_mix_q <= '0;
      mix_valid_q <= 1'b0;
    end else if (ce_in) begin
      mix_valid_q <= sample_valid_in;
      if (sample_valid_in) begin
        left_mix_q  <= mix(left_sample_in, right_sample_in, cfg_out.left_mix_left_src_en,
                           cfg_out.left_mix_right_src_en, cfg_out.left_mix_invert);
        right_mix_q <= mix(left_sample_in, right_sample_in, cfg_out.right_mix_left_src_en,
                           cfg_out.right_mix_right_src_en, cfg_out.right_mix_invert);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt request

  logic usb_q;
  logic irq_q;
  logic irq_d;

  // masked short level and USB edges
  assign irq_d = (interrupt_enable_mask_q[ADCR_BIT_IRQ_HS] & hs_s) |
                 (interrupt_enable_mask_q[ADCR_BIT_IRQ_RISE] & usb_s & ~usb_q) |
                 (interrupt_enable_mask_q[ADCR_BIT_IRQ_FALL] & ~usb_s & usb_q);
  assign irq_out = irq_q;

  // Interrupt flop and USB history
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      usb_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce_in) begin
      usb_q <= usb_s;
      irq_q <= irq_d;
    end
  end

endmodule

`default_nettype wire

//--- adcr_pkg.sv
`default_nettype none

package adcr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets on the serial control port (7-bit addresses)
  localparam logic [6:0] ADCR_OFS_MIXER_CONTROL  = 7'h08;
  localparam logic [6:0] ADCR_OFS_CLOCK_RATIO    = 7'h09;
  localparam logic [6:0] ADCR_OFS_FORMAT_FILTER  = 7'h0A;
  localparam logic [6:0] ADCR_OFS_POWER_PRECHG   = 7'h0C;
  localparam logic [6:0] ADCR_OFS_SOFT_RESET     = 7'h10;
  localparam logic [6:0] ADCR_OFS_FLAGS_STATUS   = 7'h11;
  localparam logic [6:0] ADCR_OFS_IRQ_MASK       = 7'h12;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] ADCR_RST_MIXER_CONTROL  = 8'h09;
  localparam logic [7:0] ADCR_RST_CLOCK_RATIO    = 8'h00;
  localparam logic [7:0] ADCR_RST_FORMAT_FILTER  = 8'h02;
  localparam logic [7:0] ADCR_RST_POWER_PRECHG   = 8'h00;
  localparam logic [7:0] ADCR_RST_SOFT_RESET     = 8'h00;
  localparam logic [7:0] ADCR_RST_IRQ_MASK       = 8'h00;

  // Implemented bits; all others read zero and ignore writes
  localparam logic [7:0] ADCR_MSK_MIXER_CONTROL  = 8'h3F;
  localparam logic [7:0] ADCR_MSK_CLOCK_RATIO    = 8'h10;
  localparam logic [7:0] ADCR_MSK_FORMAT_FILTER  = 8'h3F;
  localparam logic [7:0] ADCR_MSK_POWER_PRECHG   = 8'h3F;
  localparam logic [7:0] ADCR_MSK_SOFT_RESET     = 8'h03;
  localparam logic [7:0] ADCR_MSK_FLAGS_STATUS   = 8'h03;
  localparam logic [7:0] ADCR_MSK_IRQ_MASK       = 8'h07;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ADCR_BIT_LMIX_L     = 0;
  localparam int ADCR_BIT_LMIX_R     = 1;
  localparam int ADCR_BIT_RMIX_L     = 2;
  localparam int ADCR_BIT_RMIX_R     = 3;
  localparam int ADCR_BIT_LMIX_INV   = 4;
  localparam int ADCR_BIT_RMIX_INV   = 5;
  localparam int ADCR_BIT_MCLK_RATIO = 4;
  localparam int ADCR_BIT_SLEN_LO    = 0;
  localparam int ADCR_BIT_DEEMPH     = 2;
  localparam int ADCR_BIT_DITHER     = 3;
  localparam int ADCR_BIT_FRAME_LO   = 4;
  localparam int ADCR_BIT_PWR_ON     = 0;
  localparam int ADCR_BIT_PRECHG     = 1;
  localparam int ADCR_BIT_CORE_RSTN  = 0;
  localparam int ADCR_BIT_FILT_RSTN  = 1;
  localparam int ADCR_BIT_LOCKED     = 2;
  localparam int ADCR_BIT_HS_SHORT   = 0;
  localparam int ADCR_BIT_USB        = 1;
  localparam int ADCR_BIT_IRQ_HS     = 0;
  localparam int ADCR_BIT_IRQ_RISE   = 1;
  localparam int ADCR_BIT_IRQ_FALL   = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame: R/W bit, 7 address bits, 8 data bits
  localparam logic [3:0] ADCR_HDR_LAST_BIT  = 4'h7;
  localparam logic [3:0] ADCR_DATA_FIRST    = 4'h8;
  localparam logic [3:0] ADCR_DATA_LAST_BIT = 4'hF;

  // Sample length and framing encodings
  localparam logic [1:0] ADCR_SLEN_16 = 2'h0;
  localparam logic [1:0] ADCR_SLEN_18 = 2'h1;
  localparam logic [1:0] ADCR_SLEN_20 = 2'h2;
  localparam logic [1:0] ADCR_FRAME_I2S   = 2'h0;
  localparam logic [1:0] ADCR_FRAME_LEFT  = 2'h1;
  localparam logic [1:0] ADCR_FRAME_RIGHT = 2'h2;

  // Serial port states
  typedef enum logic [3:0] {
    ADCR_ST_IDLE = 4'b0001,
    ADCR_ST_HDR  = 4'b0010,
    ADCR_ST_DATA = 4'b0100,
    ADCR_ST_DONE = 4'b1000
  } adcr_state_e;

  // Decoded control bundle
  typedef struct packed {
    logic       left_mix_left_src_en;
    logic       left_mix_right_src_en;
    logic       right_mix_left_src_en;
    logic       right_mix_right_src_en;
    logic       left_mix_invert;
    logic       right_mix_invert;
    logic       mclk_ratio_sel;
    logic [1:0] sample_len;
    logic       deemphasis_en;
    logic       dither_en;
    logic [1:0] frame_fmt;
    logic       master_power_on;
    logic       master_precharge;
    logic       left_in_precharge;
    logic       right_in_precharge;
    logic       left_out_precharge;
    logic       right_out_precharge;
    logic       core_reset_n;
    logic       filter_reset_n;
  } adcr_cfg_s;

endpackage

`default_nettype wire

//--- adcr_sync.sv
`default_nettype none

// Three-stage pin synchroniser with agreement filter
module adcr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,   // System clock
  input  wire logic             rst_in,   // Sync reset, active high
  input  wire logic             ce_in,    // Clock enable
  input  wire logic [WIDTH-1:0] pin_in,   // Asynchronous pins
  output logic      [WIDTH-1:0] sync_out  // Filtered level
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // Take new level only where stages two and three agree
  assign out_d    = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
  assign sync_out = out_q;

  // Synchroniser chain
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else if (ce_in) begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

endmodule

`default_nettype wire

//--- adcr_asserts.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Port checker for the mixer path and control registers
module adcr_asserts
  import adcr_pkg::*;
#(
  parameter int SAMPLE_W = 20
) (
  input wire logic                ref_clk_in,      // Clock
  input wire logic                rst_in,          // Reset
  input wire logic                spi_cs_n_in,     // Select
  input wire logic                sample_valid_in, // Strobe in
  input wire logic [SAMPLE_W-1:0] left_sample_in,  // Left in
  input wire logic [SAMPLE_W-1:0] right_sample_in, // Right in
  input wire logic                mix_valid_out,   // Strobe out
  input wire logic [SAMPLE_W-1:0] left_mix_out,    // Left out
  input wire logic [SAMPLE_W-1:0] right_mix_out,   // Right out
  input wire adcr_cfg_s           cfg_out,         // Controls
  input wire logic                irq_out          // Interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  // Short names for the mixer controls
  wire logic go = sample_valid_in && cfg_out.core_reset_n;
  wire logic ll = cfg_out.left_mix_left_src_en;
  wire logic lr = cfg_out.left_mix_right_src_en;
  wire logic rl = cfg_out.right_mix_left_src_en;
  wire logic rr = cfg_out.right_mix_right_src_en;
  logic [SAMPLE_W:0] sum_q; // Pair sum, one bit wider
  // Sum of the pair seen at each edge
  always_ff @(posedge ref_clk_in) begin
    sum_q <= {left_sample_in[SAMPLE_W-1], left_sample_in} + {right_sample_in[SAMPLE_W-1], right_sample_in};
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_strobe_answer:
    assert property (go |=> mix_valid_out) else $error("strobe not answered");
  a_core_held:
    assert property (!cfg_out.core_reset_n ##1 !cfg_out.core_reset_n
      |-> !mix_valid_out && left_mix_out == '0 && right_mix_out == '0) else $error("mix not held at zero");
  a_left_pass:
    assert property (go && ll && !lr && !cfg_out.left_mix_invert |=> left_mix_out == $past(left_sample_in))
      else $error("left pass wrong");
  a_left_avg:
    assert property (go && ll && lr && !cfg_out.left_mix_invert |=> left_mix_out == sum_q[SAMPLE_W:1])
      else $error("left average wrong");
  a_right_avg:
    assert property (go && rl && rr && !cfg_out.right_mix_invert |=> right_mix_out == sum_q[SAMPLE_W:1])
      else $error("right average wrong");
  a_right_invert:
    assert property (go && rl && !rr && cfg_out.right_mix_invert |=> right_mix_out == -$past(left_sample_in))
      else $error("right invert wrong");
  a_cfg_reset:
    assert property ($fell(rst_in) |-> ll && !lr && !rl && rr && cfg_out.sample_len == 2'h2
      && !cfg_out.core_reset_n) else $error("reset controls wrong");
  a_cfg_in_frame:
    assert property (!$stable(cfg_out) |-> !spi_cs_n_in) else $error("controls changed outside frame");
  // Main scenarios reached
  c_strobe: cover property (go ##1 mix_valid_out);
  c_irq: cover property ($rose(irq_out));
  c_frame: cover property ($fell(spi_cs_n_in));
endmodule

bind adcr_regs adcr_asserts #(.SAMPLE_W(SAMPLE_W)) adcr_asserts_i (.ref_clk_in, .rst_in, .spi_cs_n_in,
  .sample_valid_in, .left_sample_in, .right_sample_in, .mix_valid_out, .left_mix_out, .right_mix_out,
  .cfg_out, .irq_out);
`default_nettype wire

//--- adcr_host.sv
`default_nettype none
// Host controller on the serial control port, mode 0, slow phases
module adcr_host
  import adcr_pkg::*;
#(
  parameter int HALF = 10
) (
  input  wire logic clk_in,     // System clock
  input  wire logic miso_in,    // Data from device
  input  wire logic miso_oe_in, // Device drives data
  output logic      cs_n_out,   // Select, active low
  output logic      sclk_out,   // Serial clock
  output logic      mosi_out    // Serial data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic      last_q = 1'b0;                         // Last level seen
  wire logic line   = miso_oe_in ? miso_in : ~last_q; // Released line flips
  // Idle levels; clock stands still between frames
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  // One frame: flag, address, data; q holds the last eight bits seen
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    if (a == ADCR_OFS_SOFT_RESET) f[ADCR_BIT_LOCKED] = 1'b0;
    @(posedge clk_in);
    #1 cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out = f[i];
      repeat (HALF) @(posedge clk_in);
      #1 sclk_out = 1'b1;
      last_q = line;
      q = {q[6:0], line};
      repeat (HALF) @(posedge clk_in);
      #1 sclk_out = 1'b0;
    end
    repeat (HALF) @(posedge clk_in);
    #1 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    repeat (HALF) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

//--- adcr_regs_test.sv
`default_nettype none
module adcr_regs_test
  import adcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, valid = 1'b0, hs = 1'b0, usb = 1'b0;
  logic [19:0] ls = '0, rs = '0, lm, rm;
  logic        cs_n, sclk, mosi, miso, oe, mv, irq;
  logic [7:0]  q;
  adcr_cfg_s   cfg;
  int          n_mismatch = 0, checks_done = 0;
  logic [6:0]  ofs [8] = '{7'h08, 7'h09, 7'h0A, 7'h0C, 7'h10, 7'h11, 7'h12, 7'h13};
  logic [7:0]  ffv [8] = '{8'h3F, 8'h10, 8'h3F, 8'h3F, 8'h03, 8'h00, 8'h07, 8'h00};
  logic [7:0]  rsv [8] = '{8'h09, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Clock and parts
  always #5 clk = ~clk;
  adcr_regs adcr_regs_i (.ref_clk_in(clk), .rst_in(rst), .ce_in(1'b1), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe), .headset_short_in(hs), .usb_supply_in(usb),
    .sample_valid_in(valid), .left_sample_in(ls), .right_sample_in(rs), .mix_valid_out(mv), .left_mix_out(lm),
    .right_mix_out(rm), .cfg_out(cfg), .irq_out(irq));
  adcr_host adcr_host_i (.clk_in(clk), .miso_in(miso), .miso_oe_in(oe), .cs_n_out(cs_n), .sclk_out(sclk),
    .mosi_out(mosi));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    adcr_host_i.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    adcr_host_i.xfer(1'b1, a, 8'h00, q);
    check(q, exp);
  endtask
  // Expected mixer result: mean of two, one passed, none zero, negate
  function automatic logic [19:0] mixf(input logic ea, eb, inv, input logic [19:0] a, b);
    logic signed [20:0] s;
    s = ea && eb ? ($signed({a[19], a}) + $signed({b[19], b})) >>> 1 : ea ? $signed({a[19], a})
      : eb ? $signed({b[19], b}) : 21'sh0;
    return inv ? 20'(-s) : s[19:0];
  endfunction
  // One strobe, judged one cycle later
  task automatic strobe(input logic [7:0] m, input logic [19:0] l, r, input logic on);
    valid = 1'b1;
    ls = l;
    rs = r;
    @(posedge clk);
    #1 check(mv, on);
    check(lm, on ? mixf(m[0], m[1], m[4], l, r) : 20'h0);
    check(rm, on ? mixf(m[2], m[3], m[5], l, r) : 20'h0);
  endtask
  task automatic cnt_irq(input int exp);
    int n;
    n = 0;
    repeat (12) begin
      @(posedge clk);
      #1 if (irq === 1'b1) n++;
    end
    check(n, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(cfg, 32'h0012_2000);
    check({oe, miso}, 2'h0);
    for (int i = 0; i < 8; i++) rd(ofs[i], rsv[i]);
    $display("reset test done");
  endtask
  task automatic t_regs;
    for (int i = 0; i < 8; i++) wr(ofs[i], 8'hFF);
    check(cfg, 32'h001F_FFFF);
    for (int i = 0; i < 8; i++) rd(ofs[i], ffv[i]);
    for (int i = 0; i < 8; i++) wr(ofs[i], 8'h00);
    for (int i = 0; i < 8; i++) rd(ofs[i], 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(7'h0A, {2'h0, 2'(i), 2'(i), 2'(i)});
      check({cfg.sample_len, cfg.dither_en, cfg.deemphasis_en, cfg.frame_fmt}, {2'(i), 2'(i), 2'(i)});
    end
    $display("register test done");
  endtask
  task automatic t_mix;
    logic [7:0] m [8] = '{8'h01, 8'h02, 8'h03, 8'h0C, 8'h1B, 8'h26, 8'h00, 8'h3F};
    wr(7'h10, 8'h03);
    for (int i = 0; i < 8; i++) begin
      wr(7'h08, m[i]);
      #1 strobe(m[i], 20'h00064, 20'hFFFCE, 1'b1);
      strobe(m[i], 20'h80000, 20'h7FFFF, 1'b1);
      valid = 1'b0;
    end
    wr(7'h10, 8'h00);
    #1 strobe(8'h3F, 20'h00064, 20'h00032, 1'b0);
    valid = 1'b0;
    $display("mixer test done");
  endtask
  task automatic t_irq;
    #1 hs = 1'b1;
    cnt_irq(0);
    rd(7'h11, 8'h01);
    wr(7'h12, 8'h01);
    cnt_irq(12);
    hs = 1'b0;
    wr(7'h12, 8'h02);
    #1 usb = 1'b1;
    cnt_irq(1);
    rd(7'h11, 8'h02);
    #1 usb = 1'b0;
    cnt_irq(0);
    wr(7'h12, 8'h04);
    #1 usb = 1'b1;
    cnt_irq(0);
    usb = 1'b0;
    cnt_irq(1);
    $display("interrupt test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    t_reset;
    t_regs;
    t_mix;
    t_irq;
    close_out;
  end
  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
endmodule
`default_nettype wire
